// >>> cpu_async_bus_interface.sv
// top of the asynchronous bus master: cycle sequencing, sizing, arbitration,
// interrupt level, cache inhibit, reset and halt pins
// assumes: core side is synchronous; bus pins are synchronised here
// Operation
// RQ1: drive the 3-bit space code of the request on each cycle.
// RQ2: drive the 32-bit address; cpu-space cycles carry processor information instead.
// RQ3: size outputs report operand bytes still to move in this cycle.
// RQ4: cycle start pulses low in the first clock of every bus cycle.
// RQ5: cached fetch may abort after cycle start with no address strobe.
// RQ6: operand start pulses like cycle start, first cycle of operand only.
// RQ7: locked output stays low across a whole read-modify-write sequence.
// RQ8: address strobe asserted only while space, address, size, direction are valid.
// RQ9: data strobe asks slave to drive on reads, marks write data valid.
// RQ10: direction is high for reads and low for writes.
// RQ11: buffer enable negated around any change of direction.
// RQ12: width acknowledge ends the cycle, latching data on reads.
// RQ13: both acknowledges synchronised, skew of half a clock tolerated.
// RQ14: cache disabled while synchronised inhibit is asserted.
// RQ15: interrupt pins decode to a binary level; seven is unmaskable.
// RQ16: waiting output asserted when level beats mask or nmi seen.
// RQ17: auto vector request in acknowledge cycle yields internal vector.
// RQ18: alternate masters share the wired request line.
// RQ19: grant output says the bus is released after this cycle.
// RQ20: new master takes bus only after grant and idle strobes.
// RQ21: incoming reset starts reset processing; device may drive reset pin.
// RQ22: halt stops after current cycle; double fault drives halt.
// RQ23: narrow port acknowledge latches valid part and runs further cycles.
module cpu_async_bus_interface
	import cpu_bus_pkg::*;
#(
	parameter int FIFO_DEPTH = RD_FIFO_DEPTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// core requests
	input wire logic req_valid,
	output logic req_ready,
	input wire bus_req_t req_in,
	input wire logic fetch_hit,
	output logic fetch_aborted,
	output logic write_done,
	// read results
	output logic rd_valid,
	input wire logic rd_ready,
	output rd_word_t rd_word,
	// core status
	input wire logic [2:0] irq_mask,
	input wire logic nmi_taken,
	output logic [2:0] irq_level,
	output logic cache_enable,
	input wire logic reset_drive,
	output logic reset_exception,
	input wire logic double_fault,
	// address side pins
	output logic bus_oe,
	output logic [2:0] space_code,
	output logic [31:0] addr_out,
	output logic transfer_size_lo,
	output logic transfer_size_hi,
	output logic read_write,
	// data pins
	input wire logic [31:0] data_in,
	output logic [31:0] data_out,
	output logic data_oe,
	// strobes and acknowledges
	output logic external_cycle_start_n,
	output logic operand_cycle_start_n,
	output logic locked_cycle_n,
	output logic address_valid_strobe_n,
	output logic data_valid_strobe_n,
	output logic buffer_enable_n,
	input wire logic ack_width_0_n,
	input wire logic ack_width_1_n,
	// cache, interrupt and arbitration pins
	input wire logic cache_inhibit_n,
	input wire logic [2:0] irq_level_in,
	output logic irq_waiting_n,
	input wire logic auto_vector_req_n,
	input wire logic mastership_request_n,
	output logic mastership_grant_n,
	input wire logic mastership_taken_n,
	// open-drain reset and halt
	input wire logic reset_pin_in,
	output logic reset_pin_out,
	output logic reset_pin_oe,
	input wire logic halt_pin_in,
	output logic halt_pin_out,
	output logic halt_pin_oe
);
	// ==========================================================
	// declarations
	bus_state_t state_reg, state_next;
	bus_req_t req_reg;
	pin_in_t pins_s;
	logic [31:0] op_reg;
	logic [31:0] addr_reg, addr_next;
	logic [2:0] done_reg, done_next;
	logic [2:0] n_reg, take, rem, rem_next;
	logic [1:0] ack_prev_reg;
	logic auto_vector_req_n_prev_reg, av_reg, locked_reg, locked_next;
	logic nmi_reg, reset_prev_reg, fault_reg;
	logic [2:0] lvl, lvl_prev_reg;
	logic accept, abort, last, term_ok, av_ok, iack, grant, push, fifo_ready;
	rd_word_t push_word;

	// which data lane carries byte k of this cycle
	function automatic logic [1:0] lane_of(input logic [1:0] ack, input logic [1:0] a, input logic [1:0] k);
		case (ack)
			ACK_PORT32: lane_of = a + k;
			ACK_PORT16: lane_of = {1'b0, a[0]} + k;
			default: lane_of = k;
		endcase
	endfunction

	// bytes moved by one cycle: limited by port width and alignment
	function automatic logic [2:0] cycle_bytes(input logic [1:0] ack, input logic [1:0] a, input logic [2:0] r);
		logic [2:0] room;
		case (ack)
			ACK_PORT32: room = OPERAND_MAX - {1'b0, a};
			ACK_PORT16: room = 3'h2 - {2'h0, a[0]};
			default: room = 3'h1;
		endcase
		cycle_bytes = (r < room) ? r : room;
	endfunction

	// write lanes copied so 8, 16 and 32-bit ports all find their bytes
	function automatic logic [31:0] write_lanes(input logic [31:0] op, input logic [2:0] d, input logic [1:0] a);
		logic [2:0] i;
		write_lanes = '0;
		for (int j = 0; j < 4; j++) begin
			if (2'(j) >= a) i = d + 3'(2'(j) - a);
			else if (2'(j) >= (a & 2'h2)) i = d + 3'(2'(j) - (a & 2'h2));
			else i = d + 3'(j);
			if (i < OPERAND_MAX) write_lanes[8*(3-j) +: 8] = op[8*(3-int'(i)) +: 8];
		end
	endfunction

	// ==========================================================
	// input synchronisers and the read fifo
	pin_sync #(.WIDTH($bits(pin_in_t)), .INIT(PINS_IDLE)) u_sync (
		.clk(clk),
		.rst(rst),
		.raw({ack_width_1_n, ack_width_0_n, cache_inhibit_n, irq_level_in, auto_vector_req_n,
			mastership_request_n, mastership_taken_n, reset_pin_in, halt_pin_in}), // RQ13
		.synced(pins_s)
	);

	word_fifo #(.WIDTH($bits(rd_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rst(rst),
		.in_valid(push),
		.in_ready(fifo_ready),
		.in_data(push_word),
		.out_valid(rd_valid),
		.out_ready(rd_ready),
		.out_data(rd_word)
	);

	// ==========================================================
	// cycle decode
	always_comb begin
		rem = 3'(req_reg.nbytes - done_reg);
		take = cycle_bytes(pins_s.ack_n, addr_reg[1:0], rem);
		// acknowledge must read the same on two samples, absorbing skew
		term_ok = pins_s.ack_n != ACK_WAIT && pins_s.ack_n == ack_prev_reg; // RQ13
		iack = req_reg.space == SPACE_CPU && req_reg.addr[CPU_TYPE_LSB +: 4] == CPU_TYPE_IACK;
		av_ok = iack && !pins_s.auto_vector_req_n_n && !auto_vector_req_n_prev_reg; // RQ17
		accept = state_reg == S_IDLE && req_valid && req_ready;
		abort = state_reg == S_START && req_reg.fetch && fetch_hit && cache_enable; // RQ5
		last = done_reg + n_reg == req_reg.nbytes;
		push = state_reg == S_TERM && last && !req_reg.write;
		grant = !pins_s.req_n && !locked_next; // RQ19
	end

	// next state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			S_IDLE: begin
				if (accept) state_next = S_START;
				else if (done_reg != '0 && pins_s.halt_n && pins_s.req_n && pins_s.taken_n) state_next = S_START;
			end
			S_START: state_next = abort ? S_IDLE : S_ADDR;
			S_ADDR: state_next = S_WAIT;
			S_WAIT: begin
				if (term_ok || av_ok) state_next = S_TERM; // RQ12
			end
			S_TERM: begin
				// halt or a waiting master takes effect between cycles
				if (last || !pins_s.halt_n || !pins_s.req_n) state_next = S_IDLE; // RQ22
				else state_next = S_START; // RQ23
			end
			default: state_next = S_IDLE;
		endcase
	end

	// operand position after this clock
	always_comb begin
		addr_next = addr_reg;
		done_next = done_reg;
		rem_next = rem;
		if (accept) begin
			addr_next = req_in.addr;
			done_next = '0;
			rem_next = req_in.nbytes;
		end else if (state_reg == S_TERM) begin
			addr_next = addr_reg + 32'(n_reg);
			done_next = last ? 3'h0 : done_reg + n_reg; // RQ23
			rem_next = 3'(rem - n_reg);
		end
		locked_next = locked_reg;
		if (accept) locked_next = req_in.lock;
		else if (abort || (state_reg == S_TERM && last && req_reg.lock_end)) locked_next = 1'b0;
	end

	// ==========================================================
	// sequencer registers
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= S_IDLE;
			req_reg <= '0;
			addr_reg <= '0;
			done_reg <= '0;
			locked_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			addr_reg <= addr_next;
			done_reg <= done_next;
			locked_reg <= locked_next;
			if (accept) req_reg <= req_in;
		end
	end

	// acknowledge history for the two-sample check
	always_ff @(posedge clk) begin
		if (rst) begin
			ack_prev_reg <= ACK_WAIT;
			auto_vector_req_n_prev_reg <= 1'b1;
		end else begin
			ack_prev_reg <= pins_s.ack_n;
			auto_vector_req_n_prev_reg <= pins_s.auto_vector_req_n_n;
		end
	end

	// operand buffer: left-justified, only valid lanes latched on reads
	always_ff @(posedge clk) begin
		if (rst) begin
			op_reg <= '0;
			n_reg <= '0;
			av_reg <= 1'b0;
		end else if (accept) begin
			op_reg <= req_in.wdata << {OPERAND_MAX - req_in.nbytes, 3'h0};
			av_reg <= 1'b0;
		end else if (state_reg == S_WAIT && av_ok) begin
			n_reg <= rem; // RQ17
			av_reg <= 1'b1;
		end else if (state_reg == S_WAIT && term_ok) begin
			n_reg <= take;
			if (!req_reg.write) begin
				for (int k = 0; k < 4; k++) begin
					if (3'(k) < take)
						op_reg[8*(3-(int'(done_reg)+k)) +: 8] <= // RQ12 RQ23
							data_in[8*(3-int'(lane_of(pins_s.ack_n, addr_reg[1:0], 2'(k)))) +: 8];
				end
			end
		end
	end

	// result word: right-justified data or internal vector
	always_comb begin
		push_word.autovec = av_reg;
		push_word.data = op_reg >> {OPERAND_MAX - req_reg.nbytes, 3'h0};
		if (av_reg) push_word.data = {24'h0, AUTOVEC_BASE + {5'h0, req_reg.addr[IACK_LEVEL_LSB +: 3]}}; // RQ17
	end

	// ==========================================================
	// bus pins, all from flip-flops
	always_ff @(posedge clk) begin
		if (rst) begin
			space_code <= '0;
			addr_out <= '0;
			{transfer_size_hi, transfer_size_lo} <= '0;
			read_write <= 1'b1;
		end else if (state_next == S_START) begin
			space_code <= accept ? req_in.space : req_reg.space; // RQ1
			addr_out <= addr_next; // RQ2
			{transfer_size_hi, transfer_size_lo} <= rem_next[1:0]; // RQ3
			read_write <= accept ? !req_in.write : !req_reg.write; // RQ10
		end
	end

	// strobes follow the next state so they line up with the address
	always_ff @(posedge clk) begin
		if (rst) begin
			external_cycle_start_n <= 1'b1;
			operand_cycle_start_n <= 1'b1;
			address_valid_strobe_n <= 1'b1;
			data_valid_strobe_n <= 1'b1;
			buffer_enable_n <= 1'b1;
			data_oe <= 1'b0;
			locked_cycle_n <= 1'b1;
		end else begin
			external_cycle_start_n <= state_next != S_START; // RQ4
			operand_cycle_start_n <= !(state_next == S_START && state_reg == S_IDLE && done_reg == '0); // RQ6
			address_valid_strobe_n <= !(state_next == S_ADDR || state_next == S_WAIT); // RQ8
			// write data strobe waits one clock for the data to settle
			data_valid_strobe_n <= !(state_next == S_WAIT || (state_next == S_ADDR && !req_reg.write)); // RQ9
			// start and term cycles leave the buffers off while direction moves
			buffer_enable_n <= !(state_next == S_ADDR || state_next == S_WAIT); // RQ11
			data_oe <= (state_next == S_ADDR || state_next == S_WAIT) && req_reg.write; // RQ9
			locked_cycle_n <= !locked_next; // RQ7
		end
	end

	// write lanes lag one clock, hidden by the write data strobe delay
	always_ff @(posedge clk) begin
		if (rst) data_out <= '0;
		else data_out <= write_lanes(op_reg, done_reg, addr_reg[1:0]);
	end

	// ==========================================================
	// core handshakes
	always_ff @(posedge clk) begin
		if (rst) begin
			req_ready <= 1'b0;
			fetch_aborted <= 1'b0;
			write_done <= 1'b0;
		end else begin
			// fifo room is checked here one clock late, so the result of a read accepted just as the fifo fills can be refused
			req_ready <= state_next == S_IDLE && done_next == '0 && pins_s.halt_n && pins_s.req_n
				&& pins_s.taken_n && fifo_ready && !fault_reg && !accept; // RQ20 RQ22
			fetch_aborted <= abort; // RQ5
			write_done <= state_reg == S_TERM && last && req_reg.write;
		end
	end

	// arbitration: grant withheld during locked sequences
	always_ff @(posedge clk) begin
		if (rst) begin
			mastership_grant_n <= 1'b1;
			bus_oe <= 1'b1;
		end else begin
			mastership_grant_n <= !grant; // RQ19 RQ7
			bus_oe <= !(state_next == S_IDLE && (grant || !pins_s.taken_n)); // RQ20
		end
	end

	// ==========================================================
	// interrupt level, cache inhibit
	assign lvl = ~pins_s.irq_n; // RQ15
	always_ff @(posedge clk) begin
		if (rst) begin
			lvl_prev_reg <= '0;
			irq_level <= '0;
			nmi_reg <= 1'b0;
			irq_waiting_n <= 1'b1;
			cache_enable <= 1'b1;
		end else begin
			lvl_prev_reg <= lvl;
			irq_level <= lvl;
			// a new level-seven edge wins over a same-cycle clear
			if (lvl == IRQ_NMI_LEVEL && lvl_prev_reg != IRQ_NMI_LEVEL) nmi_reg <= 1'b1; // RQ15
			else if (nmi_taken) nmi_reg <= 1'b0;
			irq_waiting_n <= !(lvl > irq_mask || nmi_reg); // RQ16
			cache_enable <= pins_s.cache_inh_n; // RQ14
		end
	end

	// reset and halt pins; drivers only ever pull low
	always_ff @(posedge clk) begin
		if (rst) begin
			reset_prev_reg <= 1'b1;
			reset_exception <= 1'b0;
			reset_pin_oe <= 1'b0;
			reset_pin_out <= 1'b0;
			fault_reg <= 1'b0;
			halt_pin_oe <= 1'b0;
			halt_pin_out <= 1'b0;
		end else begin
			reset_prev_reg <= pins_s.reset_n;
			// own drive is excluded so it never resets this block when reset_drive is held for three clocks or more
			reset_exception <= reset_prev_reg && !pins_s.reset_n && !reset_pin_oe; // RQ21
			reset_pin_oe <= reset_drive; // RQ21
			fault_reg <= fault_reg || double_fault;
			halt_pin_oe <= fault_reg || double_fault; // RQ22
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_size_valid: assert property (!address_valid_strobe_n |-> {transfer_size_hi, transfer_size_lo} == rem[1:0]) // RQ3
		else $error("size outputs disagree with bytes remaining");
	a_start_single: assert property ($fell(external_cycle_start_n) |=> external_cycle_start_n) // RQ4
		else $error("cycle start held beyond one clock");
	a_operand_start: assert property (!operand_cycle_start_n |-> !external_cycle_start_n) // RQ6
		else $error("operand start without cycle start");
	a_strobe_follows: assert property ($fell(address_valid_strobe_n) |-> $past(!external_cycle_start_n)) // RQ8
		else $error("address strobe without preceding cycle start");
	a_addr_steady: assert property (!address_valid_strobe_n && $past(!address_valid_strobe_n) |-> $stable(addr_out)) // RQ8
		else $error("address moved under strobe");
	a_write_data: assert property (!data_valid_strobe_n && !read_write |-> data_oe) // RQ9
		else $error("write strobe without data drive");
	a_dir_buffer: assert property ($changed(read_write) |-> buffer_enable_n && $past(buffer_enable_n)) // RQ11
		else $error("direction changed with buffers enabled");
	a_ack_ends: assert property (state_reg == S_WAIT && term_ok |=> address_valid_strobe_n // RQ12
		##1 (external_cycle_start_n || !$past(last)))
		else $error("acknowledge did not end the cycle");
	a_irq_wait: assert property (lvl > irq_mask |=> !irq_waiting_n) // RQ16
		else $error("waiting output missing for higher level");
	a_grant_lock: assert property (!mastership_grant_n |-> locked_cycle_n) // RQ7
		else $error("grant given inside locked sequence");
	a_abort_quiet: assert property (abort |=> address_valid_strobe_n [*2]) // RQ5
		else $error("aborted cycle raised address strobe");
	a_halt_drive: assert property (fault_reg |-> halt_pin_oe) // RQ22
		else $error("halt not driven after double fault");
	c_read_done: cover property (push && !av_reg);
	c_write_done: cover property (write_done);
	c_narrow_port: cover property (state_reg == S_TERM && !last ##1 !operand_cycle_start_n == 1'b0);
	c_autovector: cover property (push && av_reg);
	c_granted: cover property (!mastership_grant_n ##[1:20] !pins_s.taken_n);
endmodule

// >>> cpu_bus_pkg.sv
// package: shared codes, layouts and state types for the async bus master
// assumes: one 100 MHz clock, all pins sampled on its rising edge
package cpu_bus_pkg;
	// ==========================================================
	// address space codes
	localparam logic [2:0] SPACE_USER_DATA = 3'h1;
	localparam logic [2:0] SPACE_USER_PROG = 3'h2;
	localparam logic [2:0] SPACE_USER_DEF = 3'h3;
	localparam logic [2:0] SPACE_SUPV_DATA = 3'h5;
	localparam logic [2:0] SPACE_SUPV_PROG = 3'h6;
	localparam logic [2:0] SPACE_CPU = 3'h7;
	// ==========================================================
	// acknowledge encodings as {ack_width_1_n, ack_width_0_n}
	localparam logic [1:0] ACK_PORT32 = 2'h0;
	localparam logic [1:0] ACK_PORT16 = 2'h1;
	localparam logic [1:0] ACK_PORT8 = 2'h2;
	localparam logic [1:0] ACK_WAIT = 2'h3;
	// ==========================================================
	// cpu space layout and interrupt constants
	localparam int CPU_TYPE_LSB = 16;
	localparam logic [3:0] CPU_TYPE_IACK = 4'hf;
	localparam int IACK_LEVEL_LSB = 1;
	localparam logic [2:0] IRQ_NMI_LEVEL = 3'h7;
	localparam logic [7:0] AUTOVEC_BASE = 8'h18;
	// ==========================================================
	// sizes and reset values
	localparam int DATA_W = 32;
	localparam int RD_FIFO_DEPTH = 8;
	localparam logic [2:0] OPERAND_MAX = 3'h4;
	localparam logic [10:0] PINS_IDLE = 11'h7ff;
	// ==========================================================
	// carriers
	typedef struct packed {
		logic [2:0] space;
		logic [31:0] addr;
		logic write;
		logic [2:0] nbytes;
		logic fetch;
		logic lock;
		logic lock_end;
		logic [31:0] wdata;
	} bus_req_t;
	typedef struct packed {
		logic autovec;
		logic [31:0] data;
	} rd_word_t;
	typedef struct packed {
		logic [1:0] ack_n;
		logic cache_inh_n;
		logic [2:0] irq_n;
		logic auto_vector_req_n_n;
		logic req_n;
		logic taken_n;
		logic reset_n;
		logic halt_n;
	} pin_in_t;
	typedef enum logic [4:0] {
		S_IDLE = 5'h01,
		S_START = 5'h02,
		S_ADDR = 5'h04,
		S_WAIT = 5'h08,
		S_TERM = 5'h10
	} bus_state_t;
endpackage

// >>> pin_sync.sv
// two-stage synchroniser for a bundle of asynchronous pins
// assumes: idle level of each pin is given by INIT
module pin_sync #(
	parameter int WIDTH = 11,
	parameter logic [WIDTH-1:0] INIT = '1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// pins and synchronised copy
	input wire logic [WIDTH-1:0] raw,
	output logic [WIDTH-1:0] synced
);
	logic [WIDTH-1:0] meta_reg;
	// first stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_reg <= INIT;
			synced <= INIT;
		end else begin
			meta_reg <= raw;
			synced <= meta_reg;
		end
	end
endmodule

// >>> word_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes: single clock; flags are registered
module word_fifo #(
	parameter int WIDTH = 33,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;
	logic [AW:0] count_next;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
	assign out_data = mem[rd_ptr_reg];
	// pointers wrap at DEPTH, which need not be a power of two
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (push) wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			if (pop) rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
		end
	end
	// storage
	always_ff @(posedge clk) begin
		if (push) mem[wr_ptr_reg] <= in_data;
	end
	// registered flags so neither side sees a combinational path
	always_ff @(posedge clk) begin
		if (rst) begin
			count_reg <= '0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			count_reg <= count_next;
			in_ready <= count_next != (AW+1)'(DEPTH);
			out_valid <= count_next != '0;
		end
	end
endmodule

// >>> bus_slave_model.sv
// slave model: answers each strobed cycle with a width acknowledge or auto vector
// assumes: byte at address a reads back as a[7:0] xor 5a; long words aligned
module bus_slave_model (
	// clock
	input wire logic clk,
	// master pins
	input wire logic [31:0] addr_out,
	input wire logic address_valid_strobe_n,
	input wire logic [31:0] data_out,
	// behaviour chosen by the bench
	input wire logic [1:0] port_code,
	input wire logic use_auto_vector_req_n,
	input wire logic [3:0] delay,
	// slave pins and what was seen
	output logic [31:0] data_in,
	output logic ack_width_0_n,
	output logic ack_width_1_n,
	output logic auto_vector_req_n,
	output logic [31:0] last_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	function automatic logic [7:0] b(input logic [31:0] a);
		return a[7:0] ^ 8'h5a;
	endfunction
	// ==========================================================
	// one answer per strobe; released lines show the inverse so a stale value never passes
	initial begin
		data_in = 32'h0;
		{ack_width_1_n, ack_width_0_n} = 2'h3;
		auto_vector_req_n = 1'b1;
		last_wdata = 32'h0;
		forever begin
			@(posedge clk);
			if (address_valid_strobe_n === 1'b0) begin
				repeat (delay) @(posedge clk);
				if (port_code == 2'h2) data_in <= {4{b(addr_out)}};
				else data_in <= {b(addr_out), b(addr_out + 1), b(addr_out + 2), b(addr_out + 3)};
				last_wdata <= data_out;
				if (use_auto_vector_req_n) auto_vector_req_n <= 1'b0;
				else {ack_width_1_n, ack_width_0_n} <= port_code;
				while (address_valid_strobe_n === 1'b0) @(posedge clk);
				{ack_width_1_n, ack_width_0_n} <= 2'h3;
				auto_vector_req_n <= 1'b1;
				data_in <= ~data_in;
			end
		end
	end
endmodule

// >>> cpu_async_bus_interface_tb.sv
// self-checking bench for the async bus master, slave model on the pins
// assumes: 100 MHz clock, synchronous reset held 8 cycles
module cpu_async_bus_interface_tb;
	import cpu_bus_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, req_valid, req_ready, fetch_hit, fetch_aborted, write_done, rd_valid, rd_ready;
	bus_req_t req_in;
	rd_word_t rd_word;
	logic [2:0] irq_mask, irq_level, space_code, irq_level_in;
	logic nmi_taken, cache_enable, reset_drive, reset_exception, double_fault, bus_oe, read_write;
	logic transfer_size_lo, transfer_size_hi, data_oe, external_cycle_start_n, operand_cycle_start_n;
	logic [31:0] addr_out, data_in, data_out, last_wdata;
	logic locked_cycle_n, address_valid_strobe_n, data_valid_strobe_n, buffer_enable_n;
	logic ack_width_0_n, ack_width_1_n, cache_inhibit_n, irq_waiting_n, auto_vector_req_n;
	logic mastership_request_n, mastership_grant_n, mastership_taken_n, reset_pin_in, reset_pin_out;
	logic reset_pin_oe, halt_pin_in, halt_pin_out, halt_pin_oe, ext_reset_n, use_auto_vector_req_n;
	logic [1:0] port_code;
	logic [3:0] delay;
	int fails, checks_done, cyc, ecs_cnt, ocs_cnt, as_cnt, rexc_cnt;
	logic [37:0] seen_q[$];
	cpu_async_bus_interface uut (.*);
	bus_slave_model slave (.*);
	// open-drain pins: low while anyone pulls
	assign reset_pin_in = ext_reset_n & ~reset_pin_oe;
	assign halt_pin_in = ~halt_pin_oe;
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ==========================================================
	// monitors and hang guard
	always @(posedge clk) begin
		cyc++;
		if (external_cycle_start_n === 1'b0) ecs_cnt++;
		if (operand_cycle_start_n === 1'b0) ocs_cnt++;
		if (reset_exception === 1'b1) rexc_cnt++;
		if (cyc == 20000) begin
			fails++;
			final_report;
		end
	end
	// record what the strobe qualifies, at the moment it asserts
	always @(negedge address_valid_strobe_n) begin
		as_cnt++;
		seen_q.push_back({space_code, addr_out, transfer_size_hi, transfer_size_lo, read_write});
	end
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic [31:0] wexp(input logic [31:0] a);
		return {8'(a) ^ 8'h5a, 8'(a + 1) ^ 8'h5a, 8'(a + 2) ^ 8'h5a, 8'(a + 3) ^ 8'h5a};
	endfunction
	// request held until the edge where ready is high
	task automatic issue(input bus_req_t r);
		@(posedge clk);
		req_in <= r;
		req_valid <= 1'b1;
		do @(negedge clk); while (req_ready !== 1'b1);
		@(posedge clk);
		req_valid <= 1'b0;
	endtask
	task automatic pop(input logic [32:0] exp);
		do @(negedge clk); while (rd_valid !== 1'b1);
		check(rd_word, exp);
		@(posedge clk);
		rd_ready <= 1'b1;
		@(posedge clk);
		rd_ready <= 1'b0;
	endtask
	task automatic wait_done;
		do @(negedge clk); while (write_done !== 1'b1);
		@(posedge clk);
	endtask
	// ==========================================================
	// scenarios
	task automatic t_read8;
		int e;
		int o;
		e = ecs_cnt;
		o = ocs_cnt;
		port_code <= ACK_PORT8;
		delay <= 4'h3;
		seen_q = {};
		issue('{SPACE_USER_DATA, 32'h2002, 1'b0, 3'h4, 1'b0, 1'b0, 1'b0, 32'h0});
		pop({1'b0, wexp(32'h2002)});
		for (int i = 0; i < 4; i++) check(seen_q[i][34:1], {32'h2002 + i, 2'(4 - i)});
		check(ecs_cnt - e, 4);
		check(ocs_cnt - o, 1);
	endtask
	task automatic t_write_lock;
		port_code <= ACK_PORT32;
		delay <= 4'h1;
		seen_q = {};
		issue('{SPACE_SUPV_DATA, 32'h10000104, 1'b0, 3'h4, 1'b0, 1'b1, 1'b0, 32'h0});
		pop({1'b0, wexp(32'h10000104)});
		check(seen_q[0], {SPACE_SUPV_DATA, 32'h10000104, 3'h1});
		check(locked_cycle_n, 1'b0);
		issue('{SPACE_SUPV_DATA, 32'h10000104, 1'b1, 3'h4, 1'b0, 1'b1, 1'b1, 32'hcafe0123});
		wait_done;
		check(last_wdata, 32'hcafe0123);
		check(seen_q[1][0], 1'b0);
		repeat (3) @(negedge clk);
		check(locked_cycle_n, 1'b1);
	endtask
	task automatic t_fetch_auto_vector_req_n;
		int a;
		a = as_cnt;
		@(posedge clk);
		fetch_hit <= 1'b1;
		issue('{SPACE_USER_PROG, 32'h400, 1'b0, 3'h4, 1'b1, 1'b0, 1'b0, 32'h0});
		do @(negedge clk); while (fetch_aborted !== 1'b1);
		repeat (3) @(negedge clk);
		check(as_cnt, a);
		@(posedge clk);
		fetch_hit <= 1'b0;
		use_auto_vector_req_n <= 1'b1;
		issue('{SPACE_CPU, 32'h000f000a, 1'b0, 3'h1, 1'b0, 1'b0, 1'b0, 32'h0});
		pop({1'b1, 24'h0, AUTOVEC_BASE + 8'h5});
		use_auto_vector_req_n <= 1'b0;
	endtask
	// fill the read fifo until it refuses, then drain in order
	task automatic t_fifo;
		for (int i = 0; i < 8; i++) issue('{SPACE_USER_DATA, 32'h800 + 4 * i, 1'b0, 3'h4, 1'b0, 1'b0, 1'b0, 32'h0});
		repeat (20) @(negedge clk);
		check(req_ready, 1'b0);
		@(posedge clk);
		for (int i = 0; i < 8; i++) pop({1'b0, wexp(32'h800 + 4 * i)});
	endtask
	task automatic t_irq;
		logic [2:0] lv[4] = '{3'h0, 3'h5, 3'h3, 3'h7};
		logic [2:0] mk[4] = '{3'h0, 3'h3, 3'h5, 3'h7};
		logic [3:0] wt = 4'h5;
		for (int i = 0; i < 4; i++) begin
			irq_level_in <= ~lv[i];
			irq_mask <= mk[i];
			repeat (8) @(negedge clk);
			check(irq_level, lv[i]);
			check(irq_waiting_n, wt[i]);
			@(posedge clk);
		end
		irq_level_in <= 3'h7;
		nmi_taken <= 1'b1;
		repeat (4) @(negedge clk);
		check(irq_waiting_n, 1'b1);
		@(posedge clk);
		nmi_taken <= 1'b0;
	endtask
	task automatic t_pins;
		cache_inhibit_n <= 1'b0;
		mastership_request_n <= 1'b0;
		reset_drive <= 1'b1;
		repeat (6) @(negedge clk);
		check(cache_enable, 1'b0);
		check(mastership_grant_n, 1'b0);
		check(bus_oe, 1'b0);
		check(reset_pin_oe, 1'b1);
		check({reset_pin_out, halt_pin_out}, 2'h0);
		@(posedge clk);
		cache_inhibit_n <= 1'b1;
		mastership_request_n <= 1'b1;
		reset_drive <= 1'b0;
		repeat (6) @(negedge clk);
		check(cache_enable, 1'b1);
		@(posedge clk);
		ext_reset_n <= 1'b0;
		double_fault <= 1'b1;
		repeat (6) @(negedge clk);
		check(rexc_cnt, 1);
		check(halt_pin_oe, 1'b1);
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// ==========================================================
	// main sequence
	initial begin
		{fails, checks_done, cyc, ecs_cnt, ocs_cnt, as_cnt, rexc_cnt} = '0;
		{rst, ext_reset_n, cache_inhibit_n, mastership_request_n, mastership_taken_n} = 5'h1f;
		{req_valid, fetch_hit, rd_ready, nmi_taken, reset_drive, double_fault, use_auto_vector_req_n} = 7'h0;
		{req_in, irq_mask, irq_level_in, port_code, delay} = {$bits(bus_req_t)'(0), 3'h0, 3'h7, 2'h0, 4'h1};
		repeat (8) @(posedge clk);
		check({read_write, address_valid_strobe_n, mastership_grant_n}, 3'h7);
		rst <= 1'b0;
		t_read8;
		t_write_lock;
		t_fetch_auto_vector_req_n;
		t_fifo;
		t_irq;
		t_pins;
		final_report;
	end
endmodule
